// [common/ssi_res_pkg.sv]
// Purpose: constants for the ssi resolution configuration block
// Assumes: 16-bit parameter words, word-addressed parameter port
// Notes:   none
package ssi_res_pkg;
    // ------------------------------------------------------------
    // parameter addresses
    // ------------------------------------------------------------
    localparam logic [15:0] singleturn_bit_count_addr   = 16'h5202;
    localparam logic [15:0] multiturn_bit_count_addr    = 16'h5204;
    localparam logic [15:0] linear_resolution_bits_addr = 16'h5218;
    localparam logic [15:0] linear_extra_bits_addr      = 16'h521a;
    localparam logic [15:0] encoder_select_addr         = 16'h5220;
    localparam logic [15:0] config_status_addr          = 16'h5222;
    // ------------------------------------------------------------
    // limits and defaults
    // ------------------------------------------------------------
    localparam logic [15:0] st_min      = 16'h0008;
    localparam logic [15:0] st_max      = 16'h0019;
    localparam logic [15:0] st_default  = 16'h000d;
    localparam logic [15:0] mt_min      = 16'h0000;
    localparam logic [15:0] mt_max      = 16'h0018;
    localparam logic [15:0] mt_default  = 16'h0000;
    localparam logic [15:0] lr_min      = 16'h0008;
    localparam logic [15:0] lr_max      = 16'h0020;
    localparam logic [15:0] lr_default  = 16'h0018;
    localparam logic [15:0] le_min      = 16'h0000;
    localparam logic [15:0] le_max      = 16'h0003;
    localparam logic [15:0] le_default  = 16'h0000;
    localparam logic [16:0] total_max   = 17'h00020;
    // ------------------------------------------------------------
    // encoder selection codes
    // ------------------------------------------------------------
    localparam logic [1:0]  sel_none    = 2'h0;
    localparam logic [1:0]  sel_rotary  = 2'h1;
    localparam logic [1:0]  sel_linear  = 2'h2;
    localparam logic [1:0]  sel_default = 2'h1;
    // ------------------------------------------------------------
    // memory slots
    // ------------------------------------------------------------
    localparam logic [2:0]  slot_st  = 3'h0;
    localparam logic [2:0]  slot_mt  = 3'h1;
    localparam logic [2:0]  slot_lr  = 3'h2;
    localparam logic [2:0]  slot_le  = 3'h3;
    localparam logic [2:0]  slot_sel = 3'h4;
    localparam int          slot_count = 5;
    localparam logic [2:0]  slot_last  = 3'h4;
endpackage : ssi_res_pkg

// [design/ssi_res_store.sv]
// Purpose: persistent store for resolution settings
// Assumes: contents survive i_rst_n (retained across power-on)
// Notes:   read data registered
`timescale 1ns/1ps
module ssi_res_store #(
    parameter int depth = 5,
    parameter int aw    = 3
) (
    // clock
    input  wire logic          i_clk,
    input  wire logic          i_ce,
    // write port
    input  wire logic          i_we,
    input  wire logic [aw-1:0] i_waddr,
    input  wire logic [15:0]   i_wdata,
    // read port
    input  wire logic [aw-1:0] i_raddr,
    output logic      [15:0]   o_rdata
);
    logic [15:0] mem_ff [depth];
    always_ff @(posedge i_clk)
    begin
        if (i_ce && i_we)
        begin
            mem_ff[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_ce)
        begin
            o_rdata <= mem_ff[i_raddr];
        end
    end
endmodule : ssi_res_store

// [design/ssi_resolution_config.sv]
// Purpose: holds, checks and activates ssi frame-width settings
// Assumes: i_store_valid_n low once store holds programmed values
// Notes:   active set loaded from store after each reset release
`timescale 1ns/1ps
module ssi_resolution_config (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // parameter port
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    output logic             o_ack,
    output logic             o_err,
    // drive state
    input  wire logic        i_power_stage_on,
    input  wire logic        i_store_valid_n,
    // active frame layout
    output logic             o_active_valid,
    output logic      [1:0]  o_active_select,
    output logic      [15:0] o_active_singleturn,
    output logic      [15:0] o_active_multiturn,
    output logic      [15:0] o_active_lin_res,
    output logic      [15:0] o_active_lin_extra,
    output logic      [5:0]  o_frame_length,
    output logic      [4:0]  o_singleturn_lsb
);
    // ------------------------------------------------------------
    // synchronised power stage pin
    // ------------------------------------------------------------
    logic ps_meta_ff;
    logic ps_sync_ff;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ps_meta_ff <= 1'b1;
            ps_sync_ff <= 1'b1;
        end
        else if (i_ce)
        begin
            ps_meta_ff <= i_power_stage_on;
            ps_sync_ff <= ps_meta_ff;
        end
    end
    // ------------------------------------------------------------
    // pending (stored) copy, 16-bit words except the 2-bit select
    // ------------------------------------------------------------
    logic [15:0] st_ff;
    logic [15:0] mt_ff;
    logic [15:0] lr_ff;
    logic [15:0] le_ff;
    logic [1:0]  sel_ff;
    logic        refused_ff;
    logic        sum_err_ff;
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range
    function automatic logic sum_ok(input logic [15:0] a, input logic [15:0] b);
        sum_ok = ({1'b0, a} + {1'b0, b}) <= ssi_res_pkg::total_max;
    endfunction : sum_ok
    // ------------------------------------------------------------
    // write decode and checks
    // ------------------------------------------------------------
    logic       wr_ok;
    logic       wr_range;
    logic       wr_sum;
    logic       wr_known;
    logic [2:0] wr_slot;
    always_comb
    begin
        wr_range = 1'b0;
        wr_sum   = 1'b1;
        wr_known = 1'b1;
        wr_slot  = ssi_res_pkg::slot_st;
        case (i_addr)
            ssi_res_pkg::singleturn_bit_count_addr:
            begin
                wr_slot  = ssi_res_pkg::slot_st;
                wr_range = in_range(i_wdata, ssi_res_pkg::st_min, ssi_res_pkg::st_max);
                wr_sum   = sum_ok(i_wdata, mt_ff);
            end
            ssi_res_pkg::multiturn_bit_count_addr:
            begin
                wr_slot  = ssi_res_pkg::slot_mt;
                wr_range = in_range(i_wdata, ssi_res_pkg::mt_min, ssi_res_pkg::mt_max);
                wr_sum   = sum_ok(i_wdata, st_ff);
            end
            ssi_res_pkg::linear_resolution_bits_addr:
            begin
                wr_slot  = ssi_res_pkg::slot_lr;
                wr_range = in_range(i_wdata, ssi_res_pkg::lr_min, ssi_res_pkg::lr_max);
                wr_sum   = sum_ok(i_wdata, le_ff);
            end
            ssi_res_pkg::linear_extra_bits_addr:
            begin
                wr_slot  = ssi_res_pkg::slot_le;
                wr_range = in_range(i_wdata, ssi_res_pkg::le_min, ssi_res_pkg::le_max);
                wr_sum   = sum_ok(i_wdata, lr_ff);
            end
            ssi_res_pkg::encoder_select_addr:
            begin
                wr_slot  = ssi_res_pkg::slot_sel;
                wr_range = i_wdata <= 16'h0002;
            end
            default:
            begin
                wr_known = 1'b0;
            end
        endcase
    end
    assign wr_ok = i_wr && wr_known && wr_range && wr_sum && !ps_sync_ff;
    // ------------------------------------------------------------
    // boot sequence: load active set from store
    // ------------------------------------------------------------
    typedef enum logic [1:0] {boot_addr, boot_data, boot_done} boot_type;
    boot_type    boot_ff;
    logic [2:0]  boot_slot_ff;
    logic [2:0]  boot_prev_ff;
    logic [15:0] store_rdata;
    logic [2:0]  store_waddr;
    logic [15:0] store_wdata;
    logic        store_we;
    logic        fill_ff;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            boot_ff      <= boot_addr;
            boot_slot_ff <= 3'h0;
            boot_prev_ff <= 3'h0;
            fill_ff      <= 1'b0;
        end
        else if (i_ce)
        begin
            case (boot_ff)
                boot_addr:
                begin
                    fill_ff      <= i_store_valid_n;
                    boot_prev_ff <= boot_slot_ff;
                    boot_slot_ff <= boot_slot_ff + 3'h1;
                    boot_ff      <= boot_data;
                end
                boot_data:
                begin
                    boot_prev_ff <= boot_slot_ff;
                    boot_slot_ff <= boot_slot_ff + 3'h1;
                    if (boot_prev_ff == ssi_res_pkg::slot_last)
                    begin
                        boot_ff <= boot_done;
                    end
                end
                boot_done:
                begin
                    boot_ff <= boot_done;
                end
                default:
                begin
                    boot_ff <= boot_addr;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // pending copy update, status flags
    // ------------------------------------------------------------
    logic loading;
    assign loading = (boot_ff == boot_data) && (boot_prev_ff <= ssi_res_pkg::slot_last);
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st_ff  <= ssi_res_pkg::st_default;
            mt_ff  <= ssi_res_pkg::mt_default;
            lr_ff  <= ssi_res_pkg::lr_default;
            le_ff  <= ssi_res_pkg::le_default;
            sel_ff <= ssi_res_pkg::sel_default;
        end
        else if (i_ce)
        begin
            if (loading && !fill_ff)
            begin
                case (boot_prev_ff)
                    ssi_res_pkg::slot_st:  st_ff  <= store_rdata;
                    ssi_res_pkg::slot_mt:  mt_ff  <= store_rdata;
                    ssi_res_pkg::slot_lr:  lr_ff  <= store_rdata;
                    ssi_res_pkg::slot_le:  le_ff  <= store_rdata;
                    default:               sel_ff <= store_rdata[1:0];
                endcase
            end
            else if (wr_ok && boot_ff == boot_done)
            begin
                case (wr_slot)
                    ssi_res_pkg::slot_st:  st_ff  <= i_wdata;
                    ssi_res_pkg::slot_mt:  mt_ff  <= i_wdata;
                    ssi_res_pkg::slot_lr:  lr_ff  <= i_wdata;
                    ssi_res_pkg::slot_le:  le_ff  <= i_wdata;
                    default:               sel_ff <= i_wdata[1:0];
                endcase
            end
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            refused_ff <= 1'b0;
            sum_err_ff <= 1'b0;
        end
        else if (i_ce && i_wr && wr_known)
        begin
            refused_ff <= ps_sync_ff;
            sum_err_ff <= !wr_sum;
        end
    end
    // fill the store with defaults when it holds nothing valid
    assign store_we    = (loading && fill_ff) || (wr_ok && boot_ff == boot_done);
    assign store_waddr = loading ? boot_prev_ff : wr_slot;
    always_comb
    begin
        case (boot_prev_ff)
            ssi_res_pkg::slot_st: store_wdata = ssi_res_pkg::st_default;
            ssi_res_pkg::slot_mt: store_wdata = ssi_res_pkg::mt_default;
            ssi_res_pkg::slot_lr: store_wdata = ssi_res_pkg::lr_default;
            ssi_res_pkg::slot_le: store_wdata = ssi_res_pkg::le_default;
            default:              store_wdata = {14'h0000, ssi_res_pkg::sel_default};
        endcase
        if (!loading)
        begin
            store_wdata = i_wdata;
        end
    end
    ssi_res_store #(.depth(ssi_res_pkg::slot_count), .aw(3)) u_store (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (store_we),
        .i_waddr (store_waddr),
        .i_wdata (store_wdata),
        .i_raddr (boot_slot_ff),
        .o_rdata (store_rdata)
    );
    // ------------------------------------------------------------
    // active set, latched once at end of boot
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_active_valid      <= 1'b0;
            o_active_select     <= ssi_res_pkg::sel_none;
            o_active_singleturn <= 16'h0000;
            o_active_multiturn  <= 16'h0000;
            o_active_lin_res    <= 16'h0000;
            o_active_lin_extra  <= 16'h0000;
            o_frame_length      <= 6'h00;
            o_singleturn_lsb    <= 5'h00;
        end
        else if (i_ce && boot_ff == boot_done && !o_active_valid)
        begin
            o_active_valid      <= 1'b1;
            o_active_select     <= sel_ff;
            o_active_singleturn <= st_ff;
            o_active_multiturn  <= mt_ff;
            o_active_lin_res    <= lr_ff;
            o_active_lin_extra  <= le_ff;
            o_singleturn_lsb    <= 5'h00;
            if (sel_ff == ssi_res_pkg::sel_rotary)
            begin
                o_frame_length <= st_ff[5:0] + mt_ff[5:0];
            end
            else if (sel_ff == ssi_res_pkg::sel_linear)
            begin
                o_frame_length <= lr_ff[5:0] + le_ff[5:0];
            end
            else
            begin
                o_frame_length <= 6'h00;
            end
        end
    end
    // ------------------------------------------------------------
    // read back and acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 16'h0000;
            o_ack   <= 1'b0;
            o_err   <= 1'b0;
        end
        else if (i_ce)
        begin
            o_ack <= i_rd || i_wr;
            o_err <= (i_wr && (!wr_ok || boot_ff != boot_done)) || (i_rd && !wr_known
                     && i_addr != ssi_res_pkg::config_status_addr);
            if (i_rd)
            begin
                case (i_addr)
                    ssi_res_pkg::singleturn_bit_count_addr:   o_rdata <= st_ff;
                    ssi_res_pkg::multiturn_bit_count_addr:    o_rdata <= mt_ff;
                    ssi_res_pkg::linear_resolution_bits_addr: o_rdata <= lr_ff;
                    ssi_res_pkg::linear_extra_bits_addr:      o_rdata <= le_ff;
                    ssi_res_pkg::encoder_select_addr:         o_rdata <= {14'h0000, sel_ff};
                    ssi_res_pkg::config_status_addr:
                        o_rdata <= {12'h000, o_active_valid, sum_err_ff, refused_ff, ps_sync_ff};
                    default:                                  o_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule : ssi_resolution_config

// [tb/ssi_res_cfg_props.sv]
// Purpose: port-level checks of the resolution configuration block
// Assumes: ports of ssi_resolution_config only
// Notes:   bind at file foot
`timescale 1ns/1ps
module ssi_res_cfg_props (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    // parameter port
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        o_ack,
    input wire logic        o_err,
    input wire logic        i_power_stage_on,
    // active layout
    input wire logic        o_active_valid,
    input wire logic [1:0]  o_active_select,
    input wire logic [15:0] o_active_singleturn,
    input wire logic [15:0] o_active_multiturn,
    input wire logic [15:0] o_active_lin_res,
    input wire logic [15:0] o_active_lin_extra,
    input wire logic [5:0]  o_frame_length,
    input wire logic [4:0]  o_singleturn_lsb
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_power_held;
        i_power_stage_on [*3];
    endsequence
    sequence s_wr_taken;
        i_wr && i_ce && i_power_stage_on;
    endsequence
    wire logic rot = o_active_valid && o_active_select == 2'h1;
    wire logic lin = o_active_valid && o_active_select == 2'h2;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_power_refuse: assert property (s_power_held ##1 s_wr_taken |=> o_ack && o_err)
        else $error("write taken with power stage on");
    a_ack_follows: assert property (i_ce && (i_wr || i_rd) |=> o_ack)
        else $error("access without answer");
    a_active_hold: assert property (o_active_valid && $past(o_active_valid) |->
        $stable(o_active_singleturn) && $stable(o_active_multiturn) && $stable(o_frame_length))
        else $error("active set changed without power-on");
    a_frame_rotary: assert property (rot |->
        17'(o_frame_length) == 17'(o_active_singleturn) + 17'(o_active_multiturn) && o_singleturn_lsb == 5'h00)
        else $error("rotary frame length wrong");
    a_rot_sum_max: assert property (rot |-> 17'(o_active_singleturn) + 17'(o_active_multiturn) <= 17'h00020)
        else $error("rotary total above limit");
    a_frame_linear: assert property (lin |->
        17'(o_frame_length) == 17'(o_active_lin_res) + 17'(o_active_lin_extra))
        else $error("linear frame length wrong");
    a_st_range: assert property (o_active_valid |-> o_active_singleturn inside {[16'h0008:16'h0019]})
        else $error("single-turn out of range");
    a_mt_range: assert property (o_active_valid |-> o_active_multiturn <= 16'h0018)
        else $error("multi-turn out of range");
    a_lin_range: assert property (o_active_valid |-> o_active_lin_res inside {[16'h0008:16'h0020]}
        && o_active_lin_extra <= 16'h0003)
        else $error("linear setting out of range");
    a_sel_none: assert property (o_active_valid && o_active_select == 2'h0 |-> o_frame_length == 6'h00)
        else $error("frame length without ssi select");
endmodule : ssi_res_cfg_props

bind ssi_resolution_config ssi_res_cfg_props u_props (.i_clk, .i_rst_n, .i_ce, .i_wr, .i_rd, .o_ack, .o_err,
    .i_power_stage_on, .o_active_valid, .o_active_select, .o_active_singleturn, .o_active_multiturn,
    .o_active_lin_res, .o_active_lin_extra, .o_frame_length, .o_singleturn_lsb);

// [tb/ssi_res_host.sv]
// Purpose: parameter-port master standing for the configuring software
// Assumes: one access at a time, answer one cycle after the strobe
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
module ssi_res_host (
    // clock
    input  wire logic        i_clk,
    // parameter port
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_addr,
    output logic      [15:0] o_wdata,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_ack,
    input  wire logic        i_err
);
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 16'h0000;
    end
    // one access, driven on falling edges
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic ak, output logic er, output logic [15:0] rv);
        @(negedge i_clk);
        o_wr <= w;
        o_rd <= !w;
        o_addr <= a;
        o_wdata <= d;
        @(negedge i_clk);
        ak = i_ack;
        er = i_err;
        rv = i_rdata;
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : xfer
endmodule : ssi_res_host

// [tb/ssi_resolution_config_tb_top.sv]
// Purpose: self-checking bench for the resolution configuration block
// Assumes: i_ce held high
// Notes:   table of writes, then reset and boot cases
`timescale 1ns/1ps
module ssi_resolution_config_tb_top;
    localparam logic [15:0] a_st  = ssi_res_pkg::singleturn_bit_count_addr;
    localparam logic [15:0] a_mt  = ssi_res_pkg::multiturn_bit_count_addr;
    localparam logic [15:0] a_lr  = ssi_res_pkg::linear_resolution_bits_addr;
    localparam logic [15:0] a_le  = ssi_res_pkg::linear_extra_bits_addr;
    localparam logic [15:0] a_sel = ssi_res_pkg::encoder_select_addr;
    typedef struct packed {logic [15:0] a; logic [15:0] d; logic e; logic [15:0] rb;} row_type;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        pwr_on = 1'b0;
    logic        store_valid_n = 1'b1;
    logic        wr, rd, ack, err, av;
    logic [15:0] addr, wdata, rdata, ast, amt, alr, ale;
    logic [1:0]  asel;
    logic [5:0]  flen;
    logic [4:0]  lsb;
    int          mismatches = 0;
    int          n_checks = 0;
    row_type     rows [12] = '{
        '{a_st, 16'h0007, 1'b1, 16'h000d}, '{a_st, 16'h0008, 1'b0, 16'h0008},
        '{a_mt, 16'h0018, 1'b0, 16'h0018}, '{a_mt, 16'h0019, 1'b1, 16'h0018},
        '{a_st, 16'h0009, 1'b1, 16'h0008}, '{a_lr, 16'h0021, 1'b1, 16'h0018},
        '{a_lr, 16'h0020, 1'b0, 16'h0020}, '{a_le, 16'h0001, 1'b1, 16'h0000},
        '{a_lr, 16'h001d, 1'b0, 16'h001d}, '{a_le, 16'h0003, 1'b0, 16'h0003},
        '{a_le, 16'h0004, 1'b1, 16'h0003}, '{a_lr, 16'h0007, 1'b1, 16'h001d}};
    always #25 i_clk = ~i_clk;
    ssi_resolution_config u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_wr(wr), .i_rd(rd),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_ack(ack), .o_err(err),
        .i_power_stage_on(pwr_on), .i_store_valid_n(store_valid_n), .o_active_valid(av),
        .o_active_select(asel), .o_active_singleturn(ast), .o_active_multiturn(amt),
        .o_active_lin_res(alr), .o_active_lin_extra(ale), .o_frame_length(flen), .o_singleturn_lsb(lsb));
    ssi_res_host u_host (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata), .i_ack(ack), .i_err(err));
    task automatic chk1(input logic g, input logic e, input string m);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk1
    task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string m);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t %s got %h", $time, m, g);
        end
    endtask : chk16
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e,
                       input logic [15:0] rb);
        logic        ak, er;
        logic [15:0] rv;
        u_host.xfer(w, a, d, ak, er, rv);
        chk1(ak, 1'b1, "no ack");
        chk1(er, e, "err flag");
        if (!w)
            chk16(rv, rb, "read data");
    endtask : acc
    task automatic boot(input logic sv, input logic early);
        int n;
        @(negedge i_clk);
        i_rst_n <= 1'b0;
        repeat (8) @(negedge i_clk);
        store_valid_n <= sv;
        i_rst_n <= 1'b1;
        if (early)
            acc(1'b1, a_st, 16'h0009, 1'b1, 16'h0000);
        for (n = 0; n < 20 && av !== 1'b1; n++)
            @(negedge i_clk);
        if (av !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t boot never done", $time);
            final_report();
        end
    endtask : boot
    task automatic chk_act(input logic [1:0] s, input logic [5:0] f, input logic [15:0] st,
                           input logic [15:0] mt);
        chk16(16'(asel), 16'(s), "active select");
        chk16(16'(flen), 16'(f), "frame length");
        chk16(16'(lsb), 16'h0000, "single-turn lsb");
        chk16(ast, st, "active single-turn");
        chk16(amt, mt, "active multi-turn");
    endtask : chk_act
    initial
    begin
        boot(1'b1, 1'b1);
        chk_act(2'h1, 6'h0d, 16'h000d, 16'h0000);
        chk16(alr, 16'h0018, "lin res default");
        chk16(ale, 16'h0000, "lin extra default");
        $display("test defaults done");
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].a, rows[i].d, rows[i].e, 16'h0000);
            acc(1'b0, rows[i].a, 16'h0000, 1'b0, rows[i].rb);
        end
        $display("test table done");
        acc(1'b1, 16'h5200, 16'h0005, 1'b1, 16'h0000);
        acc(1'b0, 16'h5200, 16'h0000, 1'b1, 16'h0000);
        pwr_on <= 1'b1;
        repeat (3) @(negedge i_clk);
        acc(1'b1, a_st, 16'h000a, 1'b1, 16'h0000);
        acc(1'b0, a_st, 16'h0000, 1'b0, 16'h0008);
        acc(1'b0, ssi_res_pkg::config_status_addr, 16'h0000, 1'b0, 16'h000f);
        pwr_on <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk_act(2'h1, 6'h0d, 16'h000d, 16'h0000);
        $display("test power stage done");
        boot(1'b0, 1'b0);
        chk_act(2'h1, 6'h20, 16'h0008, 16'h0018);
        acc(1'b1, a_mt, 16'h0000, 1'b0, 16'h0000);
        boot(1'b0, 1'b0);
        chk_act(2'h1, 6'h08, 16'h0008, 16'h0000);
        acc(1'b1, a_sel, 16'h0002, 1'b0, 16'h0000);
        boot(1'b0, 1'b0);
        chk16(16'(flen), 16'h0020, "linear frame");
        chk16(alr, 16'h001d, "active lin res");
        chk16(ale, 16'h0003, "active lin extra");
        acc(1'b1, a_sel, 16'h0000, 1'b0, 16'h0000);
        boot(1'b0, 1'b0);
        chk16(16'(asel), 16'h0000, "select none");
        chk16(16'(flen), 16'h0000, "frame without select");
        $display("test reboot done");
        final_report();
    end
endmodule : ssi_resolution_config_tb_top
